// File: sfl_regs.svh
// Constants of the store-forwarding load unit.
// Assumes byte addresses and accesses of 1, 2, 4 or 8 bytes.
`ifndef SFL_REGS_SVH
`define SFL_REGS_SVH

// Cache line, deferral chunk and cache word, as log2 of bytes
`define LINE_OFS_W  6
`define CHUNK_OFS_W 4
`define WORD_OFS_W  3

// Reset values
`define PTR_RST     0
`define RESP_RST    0

`endif

// File: sfl_pkg.sv
// Types of the store-forwarding load unit.
// Assumes a 32-bit byte address and a 64-bit cache word.
package sfl_pkg;

  typedef logic [1:0] lsize_t;

  typedef struct packed {
    logic [31:0] addr;
    lsize_t      lsize;
    logic [63:0] data;
    logic        dv;
  } st_req_t;

  typedef struct packed {
    logic [3:0]  tag;
    logic [31:0] addr;
    lsize_t      lsize;
  } ld_req_t;

  typedef struct packed {
    logic [3:0]  tag;
    logic [63:0] data;
    logic        fwd;
  } ld_resp_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [63:0] data;
    logic [7:0]  be;
  } cache_wr_t;

  typedef enum logic [2:0] {
    L_IDLE, L_EVAL, L_DATA, L_DRAIN, L_RET, L_RDREQ, L_RDWAIT, L_DONE
  } ld_state_t;

endpackage

// File: store_forward_load_unit.sv
// Store buffer with store-to-load forwarding, line split and deferral.
// Assumes stores arrive in program order and every buffered store is
// older than any load presented; the cache answers one read at a time.
//
// Summary of operation
// [R1] Stores reach cache only after retirement
// [R2] Younger load takes data from buffered store
// [R3] Non-forwardable load waits until store drains
// [R4] Forward only on equal start address
// [R5] Forward only when load lies inside store
// [R6] Forwarding load waits for store data
// [R7] Unrelated loads proceed past one parked forwarding load, not past a second one in L_DATA
// [R8] Cache line is sixty-four bytes
// [R9] Line-crossing access splits into two accesses
// [R10] Sixteen or sixty-four byte crossings deferred
// [R11] Narrow load forwards only at store start
// [R12] Late store data delays then completes load
// [R13] Youngest older matching store is the candidate
`include "sfl_regs.svh"

module store_forward_load_unit
  import sfl_pkg::*;
#(
  parameter  int SB_DEPTH = 4,
  localparam int PW       = $clog2(SB_DEPTH)
)(
  // Clock and reset
  input  wire logic      core_clk_in,
  input  wire logic      rst_n_in,
  // Store side
  input  wire logic      st_valid_in,
  input  wire st_req_t   st_req_in,
  output logic           st_ready_out,
  output logic [PW-1:0]  st_idx_out,
  input  wire logic      st_data_valid_in,
  input  wire [PW-1:0]   st_data_idx_in,
  input  wire [63:0]     st_data_in,
  input  wire logic      st_retire_in,
  // Load side
  input  wire logic      ld_valid_in,
  input  wire ld_req_t   ld_req_in,
  input  wire logic      ld_oldest_in,
  output logic           ld_ready_out,
  output logic           ld_resp_valid_out,
  output ld_resp_t       ld_resp_out,
  // Data cache
  output logic           cache_rd_valid_out,
  output logic [31:0]    cache_rd_addr_out,
  input  wire logic      cache_rd_ready_in,
  input  wire logic      cache_rd_ack_in,
  input  wire [63:0]     cache_rd_data_in,
  output logic           cache_wr_valid_out,
  output cache_wr_t      cache_wr_out,
  input  wire logic      cache_wr_ready_in
);

  if (SB_DEPTH < 2 || (SB_DEPTH & (SB_DEPTH - 1)) != 0)
  begin : g_chk
    $error("SB_DEPTH must be a power of two, at least 2");
  end

  function automatic logic [32:0] end_of(input logic [31:0] a, input lsize_t s);
    end_of = {1'b0, a} + (33'h1 << s);
  endfunction

  // Access runs past a 2**ow byte boundary
  function automatic logic crosses(input logic [31:0] a, input lsize_t s, input int ow);
    logic [32:0] m;
    m       = (33'h1 << ow) - 33'h1;
    crosses = (({1'b0, a} & m) + (33'h1 << s)) > (m + 33'h1);
  endfunction

  function automatic logic [63:0] mask64(input lsize_t s);
    mask64 = 64'hFFFF_FFFF_FFFF_FFFF >> (7'd64 - (7'd8 << s));
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Store buffer
  logic [31:0]   ent_addr_r [SB_DEPTH];
  lsize_t        ent_size_r [SB_DEPTH];
  logic [63:0]   ent_data_r [SB_DEPTH];
  logic          ent_dv_r   [SB_DEPTH];
  logic          ent_v_r    [SB_DEPTH];
  logic [PW-1:0] head_r, tail_r;
  logic [PW:0]   cnt_r, cnt_nxt, ret_cnt_r;
  logic          alloc, pop, wr_beat_r, wr_busy_r;

  assign alloc   = st_valid_in && st_ready_out;
  assign cnt_nxt = cnt_r + (PW+1)'(alloc) - (PW+1)'(pop);

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      head_r       <= PW'(`PTR_RST);
      tail_r       <= PW'(`PTR_RST);
      cnt_r        <= '0;
      st_ready_out <= 1'b0;
    end
    else
    begin
      if (alloc)
        tail_r <= tail_r + 1'b1;
      if (pop)
        head_r <= head_r + 1'b1;
      cnt_r        <= cnt_nxt;
      st_ready_out <= cnt_nxt < (PW+1)'(SB_DEPTH);
    end
  end

  assign st_idx_out = tail_r;

  // Retired-but-not-drained count; retire names the oldest unretired store
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      ret_cnt_r <= '0;
    else
      ret_cnt_r <= ret_cnt_r + (PW+1)'(st_retire_in && ret_cnt_r < cnt_r) - (PW+1)'(pop);
  end

  logic [SB_DEPTH-1:0] ovl;
  logic [32:0]         ld_end;
  ld_req_t             ld_r;

  assign ld_end = end_of(ld_r.addr, ld_r.lsize);

  for (genvar i = 0; i < SB_DEPTH; i++)
  begin : g_ent
    always_ff @(posedge core_clk_in)
    begin
      if (!rst_n_in)
      begin
        ent_v_r[i]  <= 1'b0;
        ent_dv_r[i] <= 1'b0;
      end
      else if (alloc && tail_r == PW'(i))
      begin
        ent_v_r[i]    <= 1'b1;
        ent_addr_r[i] <= st_req_in.addr;
        ent_size_r[i] <= st_req_in.lsize;
        ent_data_r[i] <= st_req_in.data;
        ent_dv_r[i]   <= st_req_in.dv;
      end
      else
      begin
        if (pop && head_r == PW'(i))
          ent_v_r[i] <= 1'b0;
        if (st_data_valid_in && st_data_idx_in == PW'(i))
        begin
          ent_data_r[i] <= st_data_in;
          ent_dv_r[i]   <= 1'b1;                                      // R12
        end
      end
    end
    assign ovl[i] = ent_v_r[i] && ({1'b0, ld_r.addr} < end_of(ent_addr_r[i], ent_size_r[i]))
                    && ({1'b0, ent_addr_r[i]} < ld_end);
  end

  ////////////////////////////////////////////////////////////////////////
  // Drain to cache
  logic [7:0]   off_w;
  logic [127:0] wr_d128;
  logic [15:0]  wr_be16;
  logic         wr_split, drain_ok;

  assign off_w    = {5'h00, ent_addr_r[head_r][`WORD_OFS_W-1:0]};
  assign wr_d128  = {64'h0, ent_data_r[head_r]} << {off_w, 3'b000};
  // One enable per stored byte, 2**size of them
  assign wr_be16  = {8'h00, 8'hFF >> (4'd8 - (4'd1 << ent_size_r[head_r]))} << off_w;
  assign wr_split = crosses(ent_addr_r[head_r], ent_size_r[head_r], `WORD_OFS_W);
  assign drain_ok = ret_cnt_r != '0 && ent_dv_r[head_r];                 // R1
  assign pop      = cache_wr_valid_out && cache_wr_ready_in && (wr_beat_r || !wr_split);

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      wr_busy_r          <= 1'b0;
      wr_beat_r          <= 1'b0;
      cache_wr_valid_out <= 1'b0;
      cache_wr_out       <= '0;
    end
    else if (!wr_busy_r && drain_ok)
    begin
      wr_busy_r          <= 1'b1;
      wr_beat_r          <= 1'b0;
      cache_wr_valid_out <= 1'b1;
      cache_wr_out       <= '{{ent_addr_r[head_r][31:3], 3'b000}, wr_d128[63:0], wr_be16[7:0]};
    end
    else if (cache_wr_valid_out && cache_wr_ready_in)
    begin
      if (wr_split && !wr_beat_r)
      begin
        wr_beat_r         <= 1'b1;                                      // R9
        cache_wr_out.addr <= cache_wr_out.addr + 32'h8;
        cache_wr_out.data <= wr_d128[127:64];
        cache_wr_out.be   <= wr_be16[15:8];
      end
      else
      begin
        wr_busy_r          <= 1'b0;
        cache_wr_valid_out <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Youngest older overlapping store and forwarding decision
  logic          hit, fwd_ok;
  logic [PW-1:0] hit_idx, k_idx;

  always_comb
  begin
    hit     = 1'b0;
    hit_idx = head_r;
    k_idx   = head_r;
    for (int k = 0; k < SB_DEPTH; k++)
    begin
      k_idx = head_r + PW'(k);
      if (ovl[k_idx])
      begin
        hit     = 1'b1;                                               // R13
        hit_idx = k_idx;
      end
    end
  end

  assign fwd_ok = ent_addr_r[hit_idx] == ld_r.addr                        // R4 R11
                  && ld_r.lsize <= ent_size_r[hit_idx];                    // R5

  ////////////////////////////////////////////////////////////////////////
  // Load control
  ld_state_t     st_r, st_nxt;
  logic [PW-1:0] wait_idx_r, park_idx_r;
  ld_req_t       park_r;
  logic          park_busy_r, park_fire, park_take, rd_beat_r, ld_split, ld_defer;
  logic [63:0]   rd_lo_r, main_data_r;
  logic          main_fwd_r;
  logic [127:0]  rd_sh;

  assign ld_split  = crosses(ld_r.addr, ld_r.lsize, `WORD_OFS_W);
  assign ld_defer  = crosses(ld_r.addr, ld_r.lsize, `CHUNK_OFS_W)          // R10
                     || crosses(ld_r.addr, ld_r.lsize, `LINE_OFS_W);       // R8
  assign park_fire = park_busy_r && ent_dv_r[park_idx_r];                  // R6
  assign park_take = st_r == L_EVAL && hit && fwd_ok && !ent_dv_r[hit_idx] && !park_busy_r;
  assign rd_sh     = {cache_rd_data_in, rd_lo_r} >> {ld_r.addr[`WORD_OFS_W-1:0], 3'b000};

  always_comb
  begin
    st_nxt = st_r;
    unique case (st_r)
      L_IDLE:   if (ld_valid_in && ld_ready_out) st_nxt = L_EVAL;
      L_EVAL:
        if (hit && fwd_ok)
          st_nxt = park_take ? L_IDLE : (ent_dv_r[hit_idx] ? L_DONE : L_DATA); // R2 R7
        else if (hit)
          st_nxt = L_DRAIN;                                            // R3
        else
          st_nxt = ld_defer ? L_RET : L_RDREQ;
      L_DATA:   if (ent_dv_r[wait_idx_r]) st_nxt = L_DONE;             // R6 R12
      L_DRAIN:  if (!ent_v_r[wait_idx_r]) st_nxt = ld_defer ? L_RET : L_RDREQ;
      L_RET:    if (ld_oldest_in) st_nxt = L_RDREQ;                    // R10
      L_RDREQ:  if (cache_rd_ready_in) st_nxt = L_RDWAIT;
      L_RDWAIT: if (cache_rd_ack_in) st_nxt = (ld_split && !rd_beat_r) ? L_RDREQ : L_DONE;
      L_DONE:   if (!park_fire) st_nxt = L_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      st_r         <= L_IDLE;
      ld_ready_out <= 1'b0;
      rd_beat_r    <= 1'b0;
      main_fwd_r   <= 1'b0;
    end
    else
    begin
      st_r         <= st_nxt;
      ld_ready_out <= st_nxt == L_IDLE;
      if (st_r == L_IDLE)
        ld_r <= ld_req_in;
      if (st_r == L_EVAL)
      begin
        wait_idx_r <= hit_idx;
        rd_beat_r  <= 1'b0;
        main_fwd_r <= hit && fwd_ok;
      end
      if (st_nxt == L_DONE && (st_r == L_EVAL || st_r == L_DATA))
        main_data_r <= ent_data_r[st_r == L_EVAL ? hit_idx : wait_idx_r] & mask64(ld_r.lsize);
      if (st_r == L_RDWAIT && cache_rd_ack_in)
      begin
        rd_lo_r   <= cache_rd_data_in;
        rd_beat_r <= 1'b1;
        if (!ld_split || rd_beat_r)
          main_data_r <= (ld_split ? rd_sh[63:0]                        // R9
                                   : cache_rd_data_in >> {ld_r.addr[2:0], 3'b000})
                         & mask64(ld_r.lsize);
      end
    end
  end

  // Cache read request, one outstanding
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      cache_rd_valid_out <= 1'b0;
      cache_rd_addr_out  <= '0;
    end
    else
    begin
      cache_rd_valid_out <= st_nxt == L_RDREQ;
      // Second word already from the ack edge, before the beat flag is set
      cache_rd_addr_out  <= {ld_r.addr[31:3], 3'b000}
                            + (st_nxt == L_RDREQ && (rd_beat_r || st_r == L_RDWAIT)
                               ? 32'h8 : 32'h0);
    end
  end

  // Parked forwarding load waiting on store data
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
      park_busy_r <= 1'b0;
    else if (park_take)
    begin
      park_busy_r <= 1'b1;                                            // R7
      park_r      <= ld_r;
      park_idx_r  <= hit_idx;
    end
    else if (park_fire)
      park_busy_r <= 1'b0;
  end

  // Response, parked load wins a tie
  always_ff @(posedge core_clk_in)
  begin
    if (!rst_n_in)
    begin
      ld_resp_valid_out <= 1'b0;
      ld_resp_out       <= ld_resp_t'(`RESP_RST);
    end
    else
    begin
      ld_resp_valid_out <= park_fire || st_r == L_DONE;
      if (park_fire)
        ld_resp_out <= '{park_r.tag, ent_data_r[park_idx_r] & mask64(park_r.lsize), 1'b1}; // R2
      else if (st_r == L_DONE)
        ld_resp_out <= '{ld_r.tag, main_data_r, main_fwd_r};
    end
  end

endmodule

// File: sfl_monitor.sv
// Port checker of the store-forwarding load unit.
// Assumes it is bound onto store_forward_load_unit by the bind below.
module sfl_monitor
  import sfl_pkg::*;
#(
  parameter  int SB_DEPTH = 4,
  localparam int PW       = $clog2(SB_DEPTH)
)(
  // Clock, reset and store side
  input wire logic          core_clk_in,
  input wire logic          rst_n_in,
  input wire logic          st_valid_in,
  input wire logic          st_ready_out,
  input wire logic [PW-1:0] st_idx_out,
  input wire logic          st_retire_in,
  // Load side
  input wire logic          ld_valid_in,
  input wire logic          ld_ready_out,
  input wire logic          ld_resp_valid_out,
  input wire ld_resp_t      ld_resp_out,
  // Data cache
  input wire logic          cache_rd_valid_out,
  input wire logic [31:0]   cache_rd_addr_out,
  input wire logic          cache_rd_ready_in,
  input wire logic          cache_wr_valid_out,
  input wire cache_wr_t     cache_wr_out,
  input wire logic          cache_wr_ready_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic ret_seen_r;

  always_ff @(posedge core_clk_in)
    if (!rst_n_in)
      ret_seen_r <= 1'b0;
    else if (st_retire_in)
      ret_seen_r <= 1'b1;

  a_wr_after_retire: assert property (cache_wr_valid_out |-> ret_seen_r)
    else $error("cache write before any retire");
  a_wr_beat_hold: assert property (cache_wr_valid_out && !cache_wr_ready_in |=>
    cache_wr_valid_out && $stable(cache_wr_out))
    else $error("cache write beat not held");
  a_rd_req_hold: assert property (cache_rd_valid_out && !cache_rd_ready_in |=>
    cache_rd_valid_out && $stable(cache_rd_addr_out))
    else $error("cache read request not held");
  a_rd_word_addr: assert property (cache_rd_valid_out |-> cache_rd_addr_out[2:0] == 3'h0)
    else $error("cache read address not word aligned");
  a_wr_lane_set: assert property (cache_wr_valid_out |->
    cache_wr_out.addr[2:0] == 3'h0 && cache_wr_out.be != 8'h00)
    else $error("cache write beat malformed");
  a_st_take_idx: assert property (st_valid_in && st_ready_out |=>
    st_idx_out == PW'($past(st_idx_out) + 1))
    else $error("store index did not advance");
  a_st_full_hold: assert property (st_valid_in && !st_ready_out |=> $stable(st_idx_out))
    else $error("refused store changed index");
  a_ld_take_busy: assert property (ld_valid_in && ld_ready_out |=> !ld_ready_out)
    else $error("load slot free right after take");

  c_fwd: cover property (ld_resp_valid_out && ld_resp_out.fwd);
  c_rd_split: cover property (cache_rd_valid_out && cache_rd_addr_out[5:0] == 6'h00);
  c_wr_stall: cover property (cache_wr_valid_out && !cache_wr_ready_in);
endmodule

bind store_forward_load_unit sfl_monitor #(.SB_DEPTH(SB_DEPTH)) i_mon (.*);

// File: sfl_cache_model.sv
// Data cache model: word memory with patterned contents.
// Assumes one read at a time; slow_in makes it accept every other cycle.
module sfl_cache_model
  import sfl_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        slow_in,
  input  wire logic        rd_valid_in,
  input  wire logic [31:0] rd_addr_in,
  output logic             rd_ready_out,
  output logic             rd_ack_out,
  output logic [63:0]      rd_data_out,
  input  wire logic        wr_valid_in,
  input  wire cache_wr_t   wr_in,
  output logic             wr_ready_out
);
  logic [63:0] mem [logic [28:0]];
  logic        tog_r = 1'b0;

  function automatic logic [63:0] word(logic [28:0] w);
    return mem.exists(w) ? mem[w] : {~{w, 3'h0}, w, 3'h0};
  endfunction

  assign rd_ready_out = !slow_in || tog_r;
  assign wr_ready_out = !slow_in || tog_r;
  initial rd_ack_out = 1'b0;
  initial rd_data_out = 64'h0;

  // Between answers the data lines toggle so stale data never looks valid
  always @(posedge clk_in)
  begin : cm
    logic [63:0] t;
    t = word(wr_in.addr[31:3]);
    for (int i = 0; i < 8; i++)
      if (wr_in.be[i]) t[8*i +: 8] = wr_in.data[8*i +: 8];
    if (wr_valid_in && wr_ready_out) mem[wr_in.addr[31:3]] = t;
    tog_r <= !tog_r;
    rd_ack_out <= rd_valid_in && rd_ready_out;
    rd_data_out <= rd_valid_in && rd_ready_out ? word(rd_addr_in[31:3]) : ~rd_data_out;
  end
endmodule

// File: tb_store_forward_load_unit.sv
// Testbench of the store-forwarding load unit.
// Assumes sfl_cache_model as the data cache; inputs change at falling edges.
module tb_store_forward_load_unit
  import sfl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk = 1'b0;
  logic        rst_n, st_v, st_dv, st_ret, ld_v, oldest, slow;
  logic        st_rdy, ld_rdy, resp_v, rd_v, rd_rdy, rd_ack, wr_v, wr_rdy;
  logic [1:0]  st_idx, st_didx;
  logic [31:0] rd_addr;
  logic [63:0] st_d, rd_data;
  st_req_t     st_r;
  ld_req_t     ld_r;
  ld_resp_t    resp;
  cache_wr_t   wr;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          wr_cnt = 0;
  int          n_resp = 0;

  always #25 clk = ~clk;
  always @(posedge clk) if (wr_v && wr_rdy) wr_cnt <= wr_cnt + 1;
  always @(posedge clk) if (resp_v) n_resp <= n_resp + 1;

  store_forward_load_unit #(.SB_DEPTH(4)) i_dut (.core_clk_in(clk), .rst_n_in(rst_n),
    .st_valid_in(st_v), .st_req_in(st_r), .st_ready_out(st_rdy), .st_idx_out(st_idx),
    .st_data_valid_in(st_dv), .st_data_idx_in(st_didx), .st_data_in(st_d),
    .st_retire_in(st_ret), .ld_valid_in(ld_v), .ld_req_in(ld_r), .ld_oldest_in(oldest),
    .ld_ready_out(ld_rdy), .ld_resp_valid_out(resp_v), .ld_resp_out(resp),
    .cache_rd_valid_out(rd_v), .cache_rd_addr_out(rd_addr), .cache_rd_ready_in(rd_rdy),
    .cache_rd_ack_in(rd_ack), .cache_rd_data_in(rd_data), .cache_wr_valid_out(wr_v),
    .cache_wr_out(wr), .cache_wr_ready_in(wr_rdy));

  sfl_cache_model i_cache (.clk_in(clk), .slow_in(slow), .rd_valid_in(rd_v),
    .rd_addr_in(rd_addr), .rd_ready_out(rd_rdy), .rd_ack_out(rd_ack),
    .rd_data_out(rd_data), .wr_valid_in(wr_v), .wr_in(wr), .wr_ready_out(wr_rdy));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic store(logic [31:0] a, lsize_t s, logic [63:0] d, logic dv);
    while (!st_rdy) @(negedge clk);
    st_v = 1'b1;
    st_r = '{a, s, d, dv};
    @(negedge clk);
    st_v = 1'b0;
    @(negedge clk);
  endtask

  task automatic load(logic [3:0] t, logic [31:0] a, lsize_t s);
    while (!ld_rdy) @(negedge clk);
    ld_v = 1'b1;
    ld_r = '{t, a, s};
    @(negedge clk);
    ld_v = 1'b0;
  endtask

  task automatic retire();
    st_ret = 1'b1;
    @(negedge clk);
    st_ret = 1'b0;
    @(negedge clk);
  endtask

  task automatic resp_chk(string nm, logic [3:0] t, logic [63:0] d, logic f);
    int n;
    n = 0;
    while (!resp_v && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk({nm, " valid"}, 64'h1, 64'(resp_v));
    chk({nm, " tag"}, 64'(t), 64'(resp.tag));
    chk({nm, " data"}, d, resp.data);
    chk({nm, " fwd"}, 64'(f), 64'(resp.fwd));
    @(negedge clk);
  endtask

  // Load must stay unanswered and the cache unwritten until released
  task automatic held(string nm, logic [3:0] t, logic [63:0] d, logic by_ret);
    int r0;
    int w0;
    r0 = n_resp;
    w0 = wr_cnt;
    repeat (12) @(negedge clk);
    chk({nm, " held"}, 64'(r0), 64'(n_resp));
    chk({nm, " no write"}, 64'(w0), 64'(wr_cnt));
    if (by_ret) retire();
    else oldest = 1'b1;
    resp_chk(nm, t, d, 1'b0);
    oldest = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_fwd();
    store(32'h100, 2'h3, 64'h1122334455667788, 1'b1);
    load(4'h1, 32'h100, 2'h2);
    resp_chk("fwd", 4'h1, 64'h55667788, 1'b1);
    load(4'h2, 32'h101, 2'h0);
    held("offset", 4'h2, 64'h77, 1'b1);
  endtask

  task automatic s_part();
    slow = 1'b1;
    store(32'h12345678, 2'h1, 64'hBEEF, 1'b1);
    load(4'h3, 32'h12345678, 2'h2);
    held("partial", 4'h3, 64'h1234BEEF, 1'b1);
    slow = 1'b0;
  endtask

  task automatic s_late();
    logic [1:0] i;
    i = st_idx;
    store(32'h300, 2'h3, 64'h0, 1'b0);
    load(4'h4, 32'h300, 2'h2);
    load(4'h5, 32'h984, 2'h2);
    resp_chk("unrelated", 4'h5, 64'hFFFFF67F, 1'b0);
    st_didx = i;
    st_d = 64'hCAFE0000DEADBEEF;
    st_dv = 1'b1;
    @(negedge clk);
    st_dv = 1'b0;
    resp_chk("late", 4'h4, 64'hDEADBEEF, 1'b1);
    retire();
  endtask

  task automatic s_young();
    logic [1:0] i;
    repeat (20) @(negedge clk);
    store(32'h400, 2'h3, 64'h1111, 1'b1);
    store(32'h400, 2'h3, 64'h2222, 1'b1);
    store(32'h500, 2'h3, 64'h3, 1'b1);
    store(32'h600, 2'h3, 64'h4, 1'b1);
    i = st_idx;
    chk("full ready", 64'h0, 64'(st_rdy));
    st_v = 1'b1;
    @(negedge clk);
    st_v = 1'b0;
    chk("full idx", 64'(i), 64'(st_idx));
    load(4'h6, 32'h400, 2'h3);
    resp_chk("youngest", 4'h6, 64'h2222, 1'b1);
    repeat (4) retire();
    repeat (20) @(negedge clk);
  endtask

  task automatic s_split();
    slow = 1'b1;
    load(4'h7, 32'h5A5A5A7E, 2'h2);
    held("line split", 4'h7, 64'h5A80A5A5, 1'b0);
    load(4'h8, 32'h5A5A5A8E, 2'h2);
    held("chunk split", 4'h8, 64'h5A90A5A5, 1'b0);
    slow = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, st_v, st_dv, st_ret, ld_v, oldest, slow} = '0;
    {st_didx, st_d, st_r, ld_r} = '0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    s_fwd();
    s_part();
    s_late();
    s_young();
    s_split();
    tally_and_finish();
  end

  initial
  begin
    #50us;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
